// >>> rtl/bce_pkg.sv
// constants for the byte cpu instruction execute block
// assumes a single 25 mhz clock and a simple memory/io bus handshake
package bce_pkg;
    localparam logic [2:0] REG_ACC      = 3'h0;
    localparam logic [2:0] REG_PTR_HIGH = 3'h5;
    localparam logic [2:0] REG_PTR_LOW  = 3'h6;
    localparam logic [2:0] REG_MEMORY   = 3'h7;
    localparam logic [1:0] GRP_IMM      = 2'h0;
    localparam logic [1:0] GRP_CTL      = 2'h1;
    localparam logic [1:0] GRP_ALU      = 2'h2;
    localparam logic [1:0] GRP_MOVE     = 2'h3;
    localparam logic [2:0] LOW_INC      = 3'h0;
    localparam logic [2:0] LOW_DEC      = 3'h1;
    localparam logic [2:0] LOW_ROT      = 3'h2;
    localparam logic [2:0] LOW_RETC     = 3'h3;
    localparam logic [2:0] LOW_ALUI     = 3'h4;
    localparam logic [2:0] LOW_RST      = 3'h5;
    localparam logic [2:0] LOW_LDI      = 3'h6;
    localparam logic [2:0] LOW_RET      = 3'h7;
    localparam logic [2:0] CLOW_JMPC    = 3'h0;
    localparam logic [2:0] CLOW_CALLC   = 3'h2;
    localparam logic [2:0] CLOW_JMP     = 3'h4;
    localparam logic [2:0] CLOW_CALL    = 3'h6;
    localparam logic [2:0] ALU_ADD      = 3'h0;
    localparam logic [2:0] ALU_ADC      = 3'h1;
    localparam logic [2:0] ALU_SUB      = 3'h2;
    localparam logic [2:0] ALU_SBB      = 3'h3;
    localparam logic [2:0] ALU_AND      = 3'h4;
    localparam logic [2:0] ALU_XOR      = 3'h5;
    localparam logic [2:0] ALU_OR       = 3'h6;
    localparam logic [2:0] ALU_CMP      = 3'h7;
    localparam logic [1:0] COND_CARRY   = 2'h0;
    localparam logic [1:0] COND_ZERO    = 2'h1;
    localparam logic [1:0] COND_SIGN    = 2'h2;
    localparam logic [1:0] COND_PARITY  = 2'h3;
    localparam logic [1:0] ROT_LEFT       = 2'h0;
    localparam logic [1:0] ROT_RIGHT      = 2'h1;
    localparam logic [1:0] ROT_LEFT_CARRY = 2'h2;
    localparam int         ADDR_W       = 14;
    localparam int         STACK_DEPTH  = 8;
    localparam logic [13:0] PC_RESET    = 14'h0000;
    localparam logic [13:0] PC_ONE      = 14'h0001;
    localparam logic [7:0]  BYTE_ZERO   = 8'h00;
    localparam logic [7:0]  BYTE_ONE    = 8'h01;
    localparam logic [7:0]  OP_HALT_HI  = 8'hff;
    localparam logic [3:0]  FLAG_PAD    = 4'hf;
    typedef enum logic [1:0] {
        BCE_CYC_FETCH,
        BCE_CYC_READ,
        BCE_CYC_WRITE,
        BCE_CYC_IO
    } bce_cyc_e;
endpackage

// >>> rtl/bce_core.sv
// instruction decode and execute core of an 8-bit byte cpu
// assumes memory answers each bus request with a one-cycle done pulse
`timescale 1ns/1ps
module bce_core
    import bce_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    input  wire logic        bus_done_i,
    input  wire logic [7:0]  bus_rdata_i,
    input  wire logic        resume_i,
    output logic             bus_req_o,
    output logic [1:0]       bus_cycle_o,
    output logic [13:0]      bus_addr_o,
    output logic [7:0]       bus_wdata_o,
    output logic [7:0]       io_instr_o,
    output logic [7:0]       io_flags_o,
    output logic             stopped_o,
    output logic [3:0]       flags_o
);
    typedef enum logic [2:0] {
        BCE_FETCH,
        BCE_BYTE2,
        BCE_BYTE3,
        BCE_MEMRD,
        BCE_MEMWR,
        BCE_IO,
        BCE_HALT
    } bce_state_e;

    bce_state_e       state_r;
    logic [7:0]       regs_r [0:6];
    logic [13:0]      pc_r;
    logic [13:0]      stack_r [0:STACK_DEPTH-1];
    logic [2:0]       sp_r;
    logic [7:0]       ir_r;
    logic [7:0]       b2_r;
    logic             carry_r;
    logic             zero_r;
    logic             sign_r;
    logic             parity_r;
    logic             req_r;
    logic             busy_r;

    // field views of the current instruction
    logic [1:0]       grp;
    logic [2:0]       dst;
    logic [2:0]       src;
    logic [13:0]      ptr_addr;
    logic             cond_ok;
    logic             flag_sel;
    assign grp      = ir_r[7:6];
    assign dst      = ir_r[5:3];
    assign src      = ir_r[2:0];
    assign ptr_addr = {regs_r[REG_PTR_HIGH][5:0], regs_r[REG_PTR_LOW]};

    always_comb begin
        case (ir_r[4:3])
            COND_CARRY:  flag_sel = carry_r;
            COND_ZERO:   flag_sel = zero_r;
            COND_SIGN:   flag_sel = sign_r;
            COND_PARITY: flag_sel = parity_r;
            default:     flag_sel = carry_r;
        endcase
    end
    assign cond_ok = (flag_sel == ir_r[5]);

    // accumulator alu: add carry-out / subtract borrow in bit 8
    function automatic logic [8:0] alu_f(input logic [2:0] op, input logic [7:0] a,
                                         input logic [7:0] b, input logic c);
        logic [8:0] r;
        r = {1'b0, a};
        case (op)
            ALU_ADD: r = {1'b0, a} + {1'b0, b};
            ALU_ADC: r = {1'b0, a} + {1'b0, b} + {8'h00, c};
            ALU_SUB: r = {1'b0, a} - {1'b0, b};
            ALU_SBB: r = {1'b0, a} - {1'b0, b} - {8'h00, c};
            ALU_AND: r = {1'b0, a & b};
            ALU_XOR: r = {1'b0, a ^ b};
            ALU_OR:  r = {1'b0, a | b};
            ALU_CMP: r = {1'b0, a} - {1'b0, b};
            default: r = {1'b0, a};
        endcase
        return r;
    endfunction

    // opcode being decoded: the bus byte while it is fetched, the held one later
    logic [7:0]  cur_op;
    logic        exec_op;
    logic [7:0]  src_val;
    logic [7:0]  id_val;
    logic [7:0]  incdec_res;
    logic [7:0]  alu_b;
    logic [8:0]  alu_res;
    logic        alu_apply;
    logic        incdec_apply;
    logic        rot_apply;
    assign exec_op = busy_r && bus_done_i;
    assign cur_op  = (state_r == BCE_FETCH) ? bus_rdata_i : ir_r;
    // index 7 is never read since 111 routes to memory
    assign src_val = (cur_op[2:0] == REG_MEMORY) ? BYTE_ZERO : regs_r[cur_op[2:0]];
    assign id_val  = (cur_op[5:3] == REG_MEMORY) ? BYTE_ZERO : regs_r[cur_op[5:3]];
    assign incdec_res = cur_op[0] ? id_val - BYTE_ONE : id_val + BYTE_ONE;
    // memory and immediate operands are used straight off the bus, saving a state
    assign alu_b   = (state_r == BCE_FETCH) ? src_val : bus_rdata_i;
    assign alu_res = alu_f(cur_op[5:3], regs_r[REG_ACC], alu_b, carry_r);
    assign alu_apply = exec_op && ((state_r == BCE_FETCH && cur_op[7:6] == GRP_ALU
                                    && cur_op[2:0] != REG_MEMORY)
                                || (state_r == BCE_BYTE2 && cur_op[7:6] == GRP_IMM
                                    && cur_op[2:0] == LOW_ALUI)
                                || (state_r == BCE_MEMRD && cur_op[7:6] == GRP_ALU));
    assign incdec_apply = exec_op && state_r == BCE_FETCH && cur_op[7:6] == GRP_IMM
                          && (cur_op[2:0] == LOW_INC || cur_op[2:0] == LOW_DEC)
                          && cur_op[5:3] != REG_ACC && cur_op[5:3] != REG_MEMORY;
    assign rot_apply = exec_op && state_r == BCE_FETCH && cur_op[7:6] == GRP_IMM
                       && cur_op[2:0] == LOW_ROT && !cur_op[5];

    // bus request and state sequencing
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_r  <= BCE_FETCH;
            pc_r     <= PC_RESET;
            sp_r     <= 3'h0;
            ir_r     <= BYTE_ZERO;
            b2_r     <= BYTE_ZERO;
            req_r    <= 1'b0;
            busy_r   <= 1'b0;
            carry_r  <= 1'b0;
            zero_r   <= 1'b0;
            sign_r   <= 1'b0;
            parity_r <= 1'b0;
            bus_cycle_o <= BCE_CYC_FETCH;
            bus_addr_o  <= PC_RESET;
            bus_wdata_o <= BYTE_ZERO;
            io_instr_o  <= BYTE_ZERO;
            io_flags_o  <= BYTE_ZERO;
            stopped_o   <= 1'b0;
            for (int i = 0; i < 7; i++) regs_r[i] <= BYTE_ZERO;
            for (int i = 0; i < STACK_DEPTH; i++) stack_r[i] <= PC_RESET;
        end else if (!busy_r && state_r != BCE_HALT) begin
            // issue the bus cycle belonging to the current state
            busy_r <= 1'b1;
            req_r  <= 1'b1;
            case (state_r)
                BCE_FETCH, BCE_BYTE2, BCE_BYTE3: begin
                    bus_cycle_o <= (state_r == BCE_FETCH) ? BCE_CYC_FETCH : BCE_CYC_READ;
                    bus_addr_o  <= pc_r;
                end
                BCE_MEMRD: begin
                    bus_cycle_o <= BCE_CYC_READ;
                    bus_addr_o  <= ptr_addr;
                end
                BCE_MEMWR: begin
                    bus_cycle_o <= BCE_CYC_WRITE;
                    bus_addr_o  <= ptr_addr;
                    bus_wdata_o <= (grp == GRP_MOVE) ? src_val : b2_r;
                end
                BCE_IO: begin
                    bus_cycle_o <= BCE_CYC_IO;
                    bus_addr_o  <= {6'h00, regs_r[REG_ACC]};
                    bus_wdata_o <= regs_r[REG_ACC];
                    io_instr_o  <= ir_r;
                    io_flags_o  <= {FLAG_PAD, carry_r, parity_r, zero_r, sign_r};
                end
                default: begin
                    busy_r <= 1'b0;
                    req_r  <= 1'b0;
                end
            endcase
        end else if (state_r == BCE_HALT) begin
            if (resume_i) begin
                state_r   <= BCE_FETCH;
                stopped_o <= 1'b0;
            end
        end else begin
            // request stands until done is seen, whatever the memory latency
            if (bus_done_i) begin
                req_r  <= 1'b0;
                busy_r <= 1'b0;
                case (state_r)
                    BCE_FETCH: begin
                        ir_r  <= bus_rdata_i;
                        pc_r  <= pc_r + PC_ONE;
                        state_r <= BCE_FETCH;
                        case (bus_rdata_i[7:6])
                            GRP_MOVE: begin
                                if (bus_rdata_i == OP_HALT_HI) begin
                                    state_r   <= BCE_HALT;
                                    stopped_o <= 1'b1;
                                end else if (bus_rdata_i[2:0] == REG_MEMORY)
                                    state_r <= BCE_MEMRD;
                                else if (bus_rdata_i[5:3] == REG_MEMORY)
                                    state_r <= BCE_MEMWR;
                                else
                                    regs_r[bus_rdata_i[5:3]] <= regs_r[bus_rdata_i[2:0]];
                            end
                            GRP_ALU: begin
                                if (bus_rdata_i[2:0] == REG_MEMORY)
                                    state_r <= BCE_MEMRD;
                            end
                            GRP_CTL: begin
                                if (bus_rdata_i[0])
                                    state_r <= BCE_IO;
                                else
                                    state_r <= BCE_BYTE2;
                            end
                            default: begin
                                case (bus_rdata_i[2:0])
                                    LOW_INC, LOW_DEC: begin
                                        if (bus_rdata_i[5:3] == REG_ACC) begin
                                            state_r   <= BCE_HALT;
                                            stopped_o <= 1'b1;
                                        end
                                    end
                                    LOW_ALUI, LOW_LDI: state_r <= BCE_BYTE2;
                                    default: state_r <= BCE_FETCH;
                                endcase
                            end
                        endcase
                    end
                    BCE_BYTE2: begin
                        b2_r <= bus_rdata_i;
                        pc_r <= pc_r + PC_ONE;
                        state_r <= BCE_FETCH;
                        if (grp == GRP_CTL)
                            state_r <= BCE_BYTE3;
                        else if (src == LOW_LDI && dst == REG_MEMORY)
                            state_r <= BCE_MEMWR;
                        else if (src == LOW_LDI)
                            regs_r[dst] <= bus_rdata_i;
                    end
                    BCE_BYTE3: begin
                        state_r <= BCE_FETCH;
                        // 14-bit target; top two bits of byte three dropped
                        if (src[2] || cond_ok) begin
                            pc_r <= {bus_rdata_i[5:0], b2_r};
                            if (src[1]) begin
                                stack_r[sp_r] <= pc_r + PC_ONE;
                                sp_r <= sp_r + 3'h1;
                            end
                        end else
                            pc_r <= pc_r + PC_ONE;
                    end
                    BCE_MEMRD: begin
                        b2_r <= bus_rdata_i;
                        state_r <= BCE_FETCH;
                        if (grp == GRP_MOVE)
                            regs_r[dst] <= bus_rdata_i;
                    end
                    BCE_IO: begin
                        state_r <= BCE_FETCH;
                        if (dst[4-3+1:1] == 2'h0)
                            regs_r[REG_ACC] <= bus_rdata_i;
                    end
                    default: state_r <= BCE_FETCH;
                endcase
            end
        end
        // alu, inc/dec and rotate results land in the cycle their operand arrives
        if (!rst_i && alu_apply) begin
            if (cur_op[5:3] != ALU_CMP)
                regs_r[REG_ACC] <= alu_res[7:0];
            carry_r  <= alu_res[8];
            zero_r   <= (alu_res[7:0] == BYTE_ZERO);
            sign_r   <= alu_res[7];
            parity_r <= ~^alu_res[7:0];
        end
        if (!rst_i && incdec_apply) begin
            regs_r[cur_op[5:3]] <= incdec_res;
            zero_r   <= (incdec_res == BYTE_ZERO);
            sign_r   <= incdec_res[7];
            parity_r <= ~^incdec_res;
        end
        if (!rst_i && rot_apply) begin
            case (cur_op[4:3])
                ROT_LEFT: begin
                    regs_r[REG_ACC] <= {regs_r[REG_ACC][6:0], regs_r[REG_ACC][7]};
                    carry_r         <= regs_r[REG_ACC][7];
                end
                ROT_RIGHT: begin
                    regs_r[REG_ACC] <= {regs_r[REG_ACC][0], regs_r[REG_ACC][7:1]};
                    carry_r         <= regs_r[REG_ACC][0];
                end
                ROT_LEFT_CARRY: begin
                    regs_r[REG_ACC] <= {regs_r[REG_ACC][6:0], carry_r};
                    carry_r         <= regs_r[REG_ACC][7];
                end
                default: begin
                    regs_r[REG_ACC] <= {carry_r, regs_r[REG_ACC][7:1]};
                    carry_r         <= regs_r[REG_ACC][0];
                end
            endcase
        end
        // single-cycle execute of one-byte ops in the fetch-complete cycle follows
        if (!rst_i && busy_r && bus_done_i && state_r == BCE_FETCH
            && bus_rdata_i[7:6] == GRP_IMM) begin
            case (bus_rdata_i[2:0])
                LOW_RST: begin
                    stack_r[sp_r] <= pc_r + PC_ONE;
                    sp_r <= sp_r + 3'h1;
                    pc_r <= {8'h00, bus_rdata_i[5:3], 3'h0};
                end
                LOW_RET: begin
                    pc_r <= stack_r[sp_r - 3'h1];
                    sp_r <= sp_r - 3'h1;
                end
                LOW_RETC: begin
                    if (bus_rdata_i[5] == flag_sel_f(bus_rdata_i[4:3])) begin
                        pc_r <= stack_r[sp_r - 3'h1];
                        sp_r <= sp_r - 3'h1;
                    end
                end
                default: ;
            endcase
        end
    end

    function automatic logic flag_sel_f(input logic [1:0] cs);
        case (cs)
            COND_CARRY:  return carry_r;
            COND_ZERO:   return zero_r;
            COND_SIGN:   return sign_r;
            default:     return parity_r;
        endcase
    endfunction

    req_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        bus_req_o && !bus_done_i |=> bus_req_o && $stable(bus_addr_o) && $stable(bus_cycle_o))
        else $error("bus request dropped before done");
    logic_carry_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        alu_apply && (cur_op[5:3] == ALU_AND || cur_op[5:3] == ALU_XOR
                      || cur_op[5:3] == ALU_OR) |=> !carry_r)
        else $error("logic op left carry set");
    compare_keep_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        alu_apply && cur_op[5:3] == ALU_CMP |=> $stable(regs_r[REG_ACC]))
        else $error("compare changed the accumulator");
    rotate_flags_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        rot_apply |=> $stable(zero_r) && $stable(sign_r) && $stable(parity_r))
        else $error("rotate touched a flag other than carry");
    incdec_carry_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        incdec_apply |=> $stable(carry_r))
        else $error("inc or dec changed carry");
    restart_vec_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        exec_op && state_r == BCE_FETCH && cur_op[7:6] == GRP_IMM && cur_op[2:0] == LOW_RST
        |=> pc_r[13:6] == 8'h00 && pc_r[5:3] == $past(cur_op[5:3]) && pc_r[2:0] == 3'h0)
        else $error("restart target wrong");
    halt_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        state_r == BCE_HALT && !resume_i |=> stopped_o && !bus_req_o)
        else $error("halt left the stopped state");

    assign bus_req_o = req_r;
    assign flags_o   = {parity_r, sign_r, zero_r, carry_r};
endmodule

// >>> test/bce_mem_model.sv
// memory and port devices on the far side of the byte cpu bus
// assumes one request held until a one-cycle done pulse answers it
`timescale 1ns/1ps
module bce_mem_model
    import bce_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        bus_req_i,
    input  wire logic [1:0]  bus_cycle_i,
    input  wire logic [13:0] bus_addr_i,
    input  wire logic [7:0]  bus_wdata_i,
    input  wire logic [7:0]  io_instr_i,
    input  wire logic [7:0]  io_flags_i,
    input  wire logic [3:0]  latency_i,
    input  wire logic [7:0]  in_data_i,
    output logic             bus_done_o,
    output logic [7:0]       bus_rdata_o
);
    logic [7:0]  mem [0:16383];
    logic [3:0]  wait_r;
    logic [13:0] last_fetch;
    logic [13:0] wr_addr_q [$];
    logic [7:0]  wr_data_q [$];
    logic [7:0]  io_acc_q  [$];
    logic [7:0]  io_ins_q  [$];
    logic [7:0]  io_flg_q  [$];
    initial begin
        bus_done_o  = 1'b0;
        bus_rdata_o = 8'h00;
        wait_r      = 4'h0;
    end
    always @(posedge clk_sys_i) begin
        bus_done_o  <= 1'b0;
        // idle bus toggles so a stale byte is never mistaken for an answer
        bus_rdata_o <= ~bus_rdata_o;
        if (bus_req_i && !bus_done_o) begin
            if (wait_r < latency_i) begin
                wait_r <= wait_r + 4'h1;
            end else begin
                wait_r     <= 4'h0;
                bus_done_o <= 1'b1;
                case (bus_cycle_i)
                    BCE_CYC_WRITE: begin
                        mem[bus_addr_i] <= bus_wdata_i;
                        wr_addr_q.push_back(bus_addr_i);
                        wr_data_q.push_back(bus_wdata_i);
                    end
                    BCE_CYC_IO: begin
                        io_acc_q.push_back(bus_wdata_i);
                        io_ins_q.push_back(io_instr_i);
                        io_flg_q.push_back(io_flags_i);
                        if (io_instr_i[5:4] == 2'b00) begin
                            bus_rdata_o <= in_data_i;
                        end
                    end
                    default: begin
                        bus_rdata_o <= mem[bus_addr_i];
                        if (bus_cycle_i == BCE_CYC_FETCH) begin
                            last_fetch <= bus_addr_i;
                        end
                    end
                endcase
            end
        end
    end
endmodule

// >>> test/tb_byte_cpu_instruction_execute.sv
// self-checking bench for the byte cpu execute core
// assumes the memory model answers every bus request; programs end in halt
`timescale 1ns/1ps
module tb_byte_cpu_instruction_execute
    import bce_pkg::*;
;
    // flg is {carry, parity, zero, sign}
    typedef struct packed {
        logic [7:0] op;
        logic [7:0] b;
        logic [7:0] a;
        logic       cin;
        logic [7:0] acc;
        logic [3:0] flg;
    } bce_row_s;
    logic        clk_sys_i, rst_i, resume_i, bus_done_i, bus_req_o, stopped_o;
    logic [7:0]  bus_rdata_i, bus_wdata_o, io_instr_o, io_flags_o, in_data;
    logic [1:0]  bus_cycle_o;
    logic [13:0] bus_addr_o;
    logic [3:0]  flags_o, latency;
    int          fails, total_checks, cycles;
    // c0 after a one-byte op is a self move, so it runs as a no-op
    bce_row_s rows [0:12] = '{
        '{8'h04, 8'h01, 8'h7f, 1'b0, 8'h80, 4'h1}, '{8'h0c, 8'h00, 8'hff, 1'b1, 8'h00, 4'he},
        '{8'h14, 8'h07, 8'h05, 1'b0, 8'hfe, 4'h9}, '{8'h1c, 8'h0f, 8'h10, 1'b1, 8'h00, 4'h6},
        '{8'h24, 8'h3c, 8'hf0, 1'b1, 8'h30, 4'h4}, '{8'h2c, 8'hff, 8'haa, 1'b1, 8'h55, 4'h4},
        '{8'h34, 8'h00, 8'h00, 1'b1, 8'h00, 4'h6}, '{8'h3c, 8'h30, 8'h20, 1'b0, 8'h20, 4'hd},
        '{8'h3c, 8'h42, 8'h42, 1'b1, 8'h42, 4'h6}, '{8'h02, 8'hc0, 8'h81, 1'b0, 8'h03, 4'he},
        '{8'h0a, 8'hc0, 8'h01, 1'b0, 8'h80, 4'he}, '{8'h12, 8'hc0, 8'h40, 1'b1, 8'h81, 4'h6},
        '{8'h1a, 8'hc0, 8'h03, 1'b0, 8'h01, 4'he}};
    bce_core bce_core_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .bus_done_i(bus_done_i),
        .bus_rdata_i(bus_rdata_i), .resume_i(resume_i), .bus_req_o(bus_req_o),
        .bus_cycle_o(bus_cycle_o), .bus_addr_o(bus_addr_o), .bus_wdata_o(bus_wdata_o),
        .io_instr_o(io_instr_o), .io_flags_o(io_flags_o), .stopped_o(stopped_o),
        .flags_o(flags_o));
    bce_mem_model bce_mem_model_inst (.clk_sys_i(clk_sys_i), .bus_req_i(bus_req_o),
        .bus_cycle_i(bus_cycle_o), .bus_addr_i(bus_addr_o), .bus_wdata_i(bus_wdata_o),
        .io_instr_i(io_instr_o), .io_flags_i(io_flags_o), .latency_i(latency),
        .in_data_i(in_data), .bus_done_o(bus_done_i), .bus_rdata_o(bus_rdata_i));
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk14(input logic [13:0] got, input logic [13:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic load(input logic [13:0] at, input logic [7:0] d[]);
        foreach (d[i]) bce_mem_model_inst.mem[at + 14'(i)] = d[i];
    endtask
    // reset, then let the program run until the core stops
    task automatic boot(input logic [3:0] lat);
        int n;
        @(negedge clk_sys_i);
        latency = lat;
        rst_i = 1'b1;
        bce_mem_model_inst.wr_addr_q.delete();
        bce_mem_model_inst.wr_data_q.delete();
        bce_mem_model_inst.io_acc_q.delete();
        bce_mem_model_inst.io_ins_q.delete();
        bce_mem_model_inst.io_flg_q.delete();
        repeat (3) @(negedge clk_sys_i);
        rst_i = 1'b0;
        n = 0;
        while (stopped_o !== 1'b1 && n < 3000) begin
            @(negedge clk_sys_i);
            n++;
        end
        chk8({7'h00, stopped_o}, 8'h01);
    endtask
    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    // ceiling well above the several hundred cycles the programs need
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles >= 20000) begin
            fails++;
            results();
        end
    end
    initial begin
        rst_i = 1'b1;
        resume_i = 1'b0;
        latency = 4'h0;
        in_data = 8'h3c;
        fails = 0;
        total_checks = 0;
        cycles = 0;
        foreach (rows[i]) begin
            // carry is set by ff plus 1, cleared by and 0; both leave z=1 p=1 s=0
            if (rows[i].cin) load(14'h0000, '{8'h06, 8'hff, 8'h04, 8'h01});
            else load(14'h0000, '{8'h06, 8'h00, 8'h24, 8'h00});
            load(14'h0004, '{8'h06, rows[i].a, rows[i].op, rows[i].b, 8'h51, 8'hff});
            boot(4'h0);
            chk8(bce_mem_model_inst.io_acc_q[0], rows[i].acc);
            chk8(bce_mem_model_inst.io_flg_q[0], {4'hf, rows[i].flg});
            chk8(bce_mem_model_inst.io_ins_q[0], 8'h51);
            chk14(bce_mem_model_inst.last_fetch, 14'h0009);
            $display("row %0d done", i);
        end
        // pointer moves, inc/dec, call, restart, jumps, returns, input, slow memory
        load(14'h0000, '{8'h2e, 8'h00, 8'h36, 8'h40, 8'h3e, 8'h5a, 8'hcf, 8'h08, 8'hf9, 8'h46,
                         8'h20, 8'h00, 8'hc1, 8'h51, 8'h41, 8'h51, 8'h44, 8'h50, 8'hc0});
        load(14'h0020, '{8'h09, 8'h35, 8'h07});
        load(14'h0030, '{8'h48, 8'h38, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h2b, 8'h07});
        load(14'h0050, '{8'hff});
        boot(4'h3);
        chk14(bce_mem_model_inst.wr_addr_q[0], 14'h0040);
        chk8(bce_mem_model_inst.wr_data_q[0], 8'h5a);
        chk14(bce_mem_model_inst.wr_addr_q[1], 14'h0040);
        chk8(bce_mem_model_inst.wr_data_q[1], 8'h5b);
        chk8(bce_mem_model_inst.io_acc_q[0], 8'h5a);
        chk8(bce_mem_model_inst.io_ins_q[1], 8'h41);
        chk8({5'h00, bce_mem_model_inst.io_flg_q[1][2:0]}, 8'h04);
        chk8(bce_mem_model_inst.io_acc_q[2], 8'h3c);
        chk14(bce_mem_model_inst.last_fetch, 14'h0050);
        $display("program test done");
        results();
    end
endmodule
